/* design/sdc_cfg.svh */
// constants of the synthesizer divider configuration block
// assumes: included by bare name from design and testbench files
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// register indices and their byte addresses on the 32-bit bus
`define SDC_IDX_PLL_L 8'h00
`define SDC_IDX_PLL_H 8'h01
`define SDC_IDX_CMD 8'hf0
`define SDC_ADDR_PLL_L 32'h0000_0000
`define SDC_ADDR_PLL_H 32'h0000_0004
`define SDC_ADDR_CMD 32'h0000_03c0

// high configuration register fields
`define SDC_H_FB_HI_MSB 7
`define SDC_H_FB_HI_LSB 6
`define SDC_H_NA_MSB 5
`define SDC_H_NA_LSB 3
`define SDC_H_NB_BIT 2
`define SDC_H_P_BIT 1
`define SDC_H_LOCK_BIT 0

// command register bits
`define SDC_CMD_INC_BIT 0
`define SDC_CMD_DEC_BIT 1
`define SDC_CMD_LOAD_BIT 2
`define SDC_CMD_GET_BIT 3

// startup defaults of open configuration pins
`define SDC_DEF_FB 10'h1f4
`define SDC_DEF_NA 3'h2
`define SDC_DEF_NB 1'h0
`define SDC_DEF_P 1'h1
`define SDC_DEF_PINS 16'h13e9

// pre-division ratios
`define SDC_PRE_RATIO_P0 3'h2
`define SDC_PRE_RATIO_P1 3'h4

`endif

/* design/sdc_pkg.sv */
// types of the synthesizer divider configuration block
// assumes: compiled before the design modules
package sdc_pkg;

	// startup phase of the configuration loader
	typedef enum logic {
		SDC_WAIT,
		SDC_RUN
	} sdc_phase_t;

endpackage : sdc_pkg

/* design/sdc_sync.sv */
// two-stage synchronizer for a group of levels
// assumes: each bit is a slow level; no bus coherence needed
module sdc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule : sdc_sync

/* design/sdc_top.sv */
// divider configuration of the frequency synthesizer, AHB-Lite slave
// assumes: hresetn is the master reset; config pins are board levels
`include "sdc_cfg.svh"

module sdc_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic pin_pre_div_sel,
	input wire logic [9:0] pin_fb_div,
	input wire logic [2:0] pin_post_div_code_a,
	input wire logic pin_half_rate_sel_b,
	input wire logic serial_mode_sel,
	input wire logic pll_lock,
	output logic [9:0] fb_div_q,
	output logic pre_div_sel_q,
	output logic [2:0] post_div_code_a_q,
	output logic half_rate_sel_b_q,
	output logic [2:0] pre_div_ratio_q,
	output logic [5:0] out_a_div_q,
	output logic [6:0] out_b_div_q,
	output logic cfg_unsupported_q,
	output logic parallel_mode_q,
	output logic init_done_q
);

	// ==========================================================
	// input synchronizers
	// ==========================================================
	logic [15:0] pins_raw;
	logic [15:0] pins_s;
	logic rst_rel_s;
	logic serial_s;
	logic [9:0] pin_fb_s;
	logic [2:0] pin_na_s;
	logic pin_nb_s;
	logic pin_p_s;

	// pins are inputs only, no readback
	assign pins_raw = {serial_mode_sel, pin_half_rate_sel_b, pin_post_div_code_a, pin_fb_div, pin_pre_div_sel};

	sdc_sync #(
		.W(16),
		.RST_VAL(`SDC_DEF_PINS)
	) u_pin_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.d(pins_raw),
		.q(pins_s)
	);

	sdc_sync #(
		.W(1),
		.RST_VAL(1'h0)
	) u_rst_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.d(1'h1),
		.q(rst_rel_s)
	);

	assign pin_p_s = pins_s[0];
	assign pin_fb_s = pins_s[10:1];
	assign pin_na_s = pins_s[13:11];
	assign pin_nb_s = pins_s[14];
	assign serial_s = pins_s[15];

	// ==========================================================
	// startup phase
	// ==========================================================
	sdc_pkg::sdc_phase_t phase_q;
	sdc_pkg::sdc_phase_t phase_d;
	logic init_load;

	always_comb begin
		phase_d = phase_q;
		init_load = 1'h0;
		case (phase_q)
			sdc_pkg::SDC_WAIT: begin
				if (rst_rel_s) begin
					init_load = 1'h1;
					phase_d = sdc_pkg::SDC_RUN;
				end
			end
			sdc_pkg::SDC_RUN: begin
				phase_d = sdc_pkg::SDC_RUN;
			end
			default: begin
				phase_d = sdc_pkg::SDC_WAIT;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= sdc_pkg::SDC_WAIT;
		end else begin
			phase_q <= phase_d;
		end
	end

	// ==========================================================
	// AHB-Lite slave: address and data phase
	// ==========================================================
	logic addr_ok;
	logic wr_pend_q;
	logic [31:0] addr_q;
	logic follow_pins;
	logic wr_en;
	logic wr_l;
	logic wr_h;
	logic wr_cmd;

	assign addr_ok = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'h0;
			addr_q <= 32'h0000_0000;
		end else if (hready) begin
			wr_pend_q <= addr_ok && hwrite;
			addr_q <= haddr;
		end
	end

	assign follow_pins = (phase_q == sdc_pkg::SDC_RUN) && !serial_s;

	assign wr_en = wr_pend_q && serial_s && (phase_q == sdc_pkg::SDC_RUN);
	assign wr_l = wr_en && (addr_q == `SDC_ADDR_PLL_L);
	assign wr_h = wr_en && (addr_q == `SDC_ADDR_PLL_H);
	assign wr_cmd = wr_en && (addr_q == `SDC_ADDR_CMD);

	// ==========================================================
	// active divider settings
	// ==========================================================
	logic [9:0] fb_d;
	logic p_d;
	logic [2:0] na_d;
	logic nb_d;
	logic [7:0] reg_l_q;
	logic [7:0] reg_l_d;
	logic [6:0] reg_h_q;
	logic [6:0] reg_h_d;

	always_comb begin
		fb_d = fb_div_q;
		p_d = pre_div_sel_q;
		na_d = post_div_code_a_q;
		nb_d = half_rate_sel_b_q;
		if (init_load || follow_pins) begin
			fb_d = pin_fb_s;
			p_d = pin_p_s;
			na_d = pin_na_s;
			nb_d = pin_nb_s;
		end else if (wr_cmd) begin
			if (hwdata[`SDC_CMD_INC_BIT]) begin
				fb_d = fb_div_q + 10'h001;
			end else if (hwdata[`SDC_CMD_DEC_BIT]) begin
				fb_d = fb_div_q - 10'h001;
			end else if (hwdata[`SDC_CMD_LOAD_BIT]) begin
				fb_d = {reg_h_q[6:5], reg_l_q};
				na_d = reg_h_q[4:2];
				nb_d = reg_h_q[1];
				p_d = reg_h_q[0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fb_div_q <= `SDC_DEF_FB;
			pre_div_sel_q <= `SDC_DEF_P;
			post_div_code_a_q <= `SDC_DEF_NA;
			half_rate_sel_b_q <= `SDC_DEF_NB;
		end else begin
			fb_div_q <= fb_d;
			pre_div_sel_q <= p_d;
			post_div_code_a_q <= na_d;
			half_rate_sel_b_q <= nb_d;
		end
	end

	// ==========================================================
	// divider decode
	// ==========================================================
	logic [5:0] div_a;
	logic bad_cfg;

	always_comb begin
		case (na_d)
			3'h0: div_a = 6'h02;
			3'h1: div_a = 6'h20;
			3'h2: div_a = 6'h08;
			3'h3: div_a = 6'h0c;
			3'h4: div_a = 6'h04;
			3'h5: div_a = 6'h06;
			3'h6: div_a = 6'h10;
			default: div_a = 6'h00;
		endcase
	end

	assign bad_cfg = (na_d == 3'h7) || (nb_d && ((na_d == 3'h1) || (na_d == 3'h3)));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_div_ratio_q <= `SDC_PRE_RATIO_P1;
			out_a_div_q <= 6'h08;
			out_b_div_q <= 7'h08;
			cfg_unsupported_q <= 1'h0;
		end else begin
			pre_div_ratio_q <= p_d ? `SDC_PRE_RATIO_P1 : `SDC_PRE_RATIO_P0;
			out_a_div_q <= bad_cfg ? 6'h00 : div_a;
			if (bad_cfg) begin
				out_b_div_q <= 7'h00;
			end else if (nb_d) begin
				out_b_div_q <= {div_a, 1'h0};
			end else begin
				out_b_div_q <= {1'h0, div_a};
			end
			cfg_unsupported_q <= bad_cfg;
		end
	end

	// ==========================================================
	// configuration registers
	// ==========================================================
	always_comb begin
		reg_l_d = reg_l_q;
		reg_h_d = reg_h_q;
		if (init_load) begin
			reg_l_d = pin_fb_s[7:0];
			reg_h_d = {pin_fb_s[9:8], pin_na_s, pin_nb_s, pin_p_s};
		end else if (wr_l) begin
			reg_l_d = hwdata[7:0];
		end else if (wr_h) begin
			reg_h_d = hwdata[`SDC_H_FB_HI_MSB:`SDC_H_P_BIT];
		end else if (wr_cmd && hwdata[`SDC_CMD_GET_BIT]
			&& !hwdata[`SDC_CMD_INC_BIT] && !hwdata[`SDC_CMD_DEC_BIT] && !hwdata[`SDC_CMD_LOAD_BIT]) begin
			reg_l_d = fb_div_q[7:0];
			reg_h_d = {fb_div_q[9:8], post_div_code_a_q, half_rate_sel_b_q, pre_div_sel_q};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reg_l_q <= 8'(`SDC_DEF_FB);
			reg_h_q <= {2'h1, `SDC_DEF_NA, `SDC_DEF_NB, `SDC_DEF_P};
		end else begin
			reg_l_q <= reg_l_d;
			reg_h_q <= reg_h_d;
		end
	end

	// ==========================================================
	// read data and response
	// ==========================================================
	logic lock_q;
	logic [31:0] rd_d;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_q <= 1'h0;
		end else begin
			lock_q <= pll_lock;
		end
	end

	// register reads, served in both modes
	// reads stay open in parallel mode
	always_comb begin
		rd_d = 32'h0000_0000;
		if (haddr == `SDC_ADDR_PLL_L) begin
			rd_d = {24'h00_0000, reg_l_d};
		end else if (haddr == `SDC_ADDR_PLL_H) begin
			rd_d = {24'h00_0000, reg_h_d, lock_q};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata_q <= rd_d;
		end else if (hready) begin
			hrdata_q <= 32'h0000_0000;
		end
	end

	// zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'h1;
			hresp_q <= 1'h0;
		end else begin
			hreadyout_q <= 1'h1;
			hresp_q <= 1'h0;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;

	// ==========================================================
	// status
	// ==========================================================
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			parallel_mode_q <= 1'h0;
			init_done_q <= 1'h0;
		end else begin
			parallel_mode_q <= (phase_d == sdc_pkg::SDC_RUN) && !serial_s;
			init_done_q <= (phase_d == sdc_pkg::SDC_RUN);
		end
	end

	// hsize unused: only word transfers are issued
	logic unused_hsize;
	assign unused_hsize = ^hsize;

endmodule : sdc_top

/* tb/sdc_straps.sv */
// board strap model driving the configuration pins and mode select
// assumes: bench sets cfg and mode; pins settle just after an edge
module sdc_straps (
	input wire logic hclk,
	input wire logic [14:0] cfg,
	input wire logic mode,
	output logic pin_pre_div_sel,
	output logic [9:0] pin_fb_div,
	output logic [2:0] pin_post_div_code_a,
	output logic pin_half_rate_sel_b,
	output logic serial_mode_sel
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] strap_q = 16'h0000;
	// straps and mode held as levels
	always @(posedge hclk) begin
		strap_q <= {mode, cfg};
	end
	assign {serial_mode_sel, pin_pre_div_sel, pin_fb_div, pin_post_div_code_a, pin_half_rate_sel_b} = strap_q;
endmodule : sdc_straps

/* tb/sdc_top_monitor.sv */
// checker of the divider configuration block ports
// assumes: bound to sdc_top, one clock hclk, reset hresetn
module sdc_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [9:0] pin_fb_div,
	input wire logic serial_mode_sel,
	input wire logic [9:0] fb_div_q,
	input wire logic pre_div_sel_q,
	input wire logic [2:0] post_div_code_a_q,
	input wire logic half_rate_sel_b_q,
	input wire logic [2:0] pre_div_ratio_q,
	input wire logic [5:0] out_a_div_q,
	input wire logic [6:0] out_b_div_q,
	input wire logic cfg_unsupported_q,
	input wire logic parallel_mode_q,
	input wire logic init_done_q
);
	timeunit 1ns;
	timeprecision 100ps;
	logic rd_phase_q;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_phase_q <= 1'b0;
		end else begin
			rd_phase_q <= hsel && hready && htrans[1] && !hwrite;
		end
	end
	a_pre_ratio: assert property (pre_div_ratio_q == (pre_div_sel_q ? 3'h4 : 3'h2))
		else $error("pre ratio wrong");
	a_half_rate: assert property (!cfg_unsupported_q |->
		out_b_div_q == (half_rate_sel_b_q ? {out_a_div_q, 1'b0} : {1'b0, out_a_div_q})) else $error("out b wrong");
	a_unsup_flag: assert property (cfg_unsupported_q == (post_div_code_a_q == 3'h7 ||
		(half_rate_sel_b_q && post_div_code_a_q inside {3'h1, 3'h3}))) else $error("unsupported flag wrong");
	a_code_one: assert property (post_div_code_a_q == 3'h1 && !cfg_unsupported_q |-> out_a_div_q == 6'h20)
		else $error("code one not 32");
	a_pin_follow: assert property (parallel_mode_q && $past(parallel_mode_q) && $past(parallel_mode_q, 2)
		|-> fb_div_q == $past(pin_fb_div, 3)) else $error("pins not followed");
	a_init_capture: assert property ($rose(init_done_q) |-> fb_div_q == $past(pin_fb_div, 3))
		else $error("startup capture wrong");
	a_mode_lag: assert property ($rose(serial_mode_sel) && init_done_q |-> ##[1:4] !parallel_mode_q)
		else $error("mode change not seen");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or error");
	a_rd_idle: assert property (!rd_phase_q |-> hrdata == 32'h0)
		else $error("read data outside data phase");
endmodule : sdc_monitor
bind sdc_top sdc_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_fb_div(pin_fb_div),
	.serial_mode_sel(serial_mode_sel), .fb_div_q(fb_div_q), .pre_div_sel_q(pre_div_sel_q),
	.post_div_code_a_q(post_div_code_a_q), .half_rate_sel_b_q(half_rate_sel_b_q), .pre_div_ratio_q(pre_div_ratio_q),
	.out_a_div_q(out_a_div_q), .out_b_div_q(out_b_div_q), .cfg_unsupported_q(cfg_unsupported_q),
	.parallel_mode_q(parallel_mode_q), .init_done_q(init_done_q));

/* tb/tb_synth_divider_config.sv */
// testbench of the divider configuration block
// assumes: straps model drives the pins, bench is the bus master
`include "sdc_cfg.svh"
module tb_synth_divider_config;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hready, hreadyout, hresp, pll_lock, mode, rdy_q;
	logic p_pre, p_half, smode, preq, halfq, unsup, pm, idn;
	logic [1:0] htrans;
	logic [2:0] hsize, p_code, codeq, ratio;
	logic [9:0] p_fb, fbq;
	logic [5:0] oa;
	logic [6:0] ob;
	logic [31:0] haddr, hwdata, hrdata, rd_q, r;
	logic [14:0] cfg, c;
	logic [5:0] na_tbl [8] = '{6'h02, 6'h20, 6'h08, 6'h0c, 6'h04, 6'h06, 6'h10, 6'h00};
	int miscompares, checks_done, n;
	wire [31:0] cfg_vec = {fbq, preq, codeq, halfq, ratio, oa, ob, unsup};
	always #12.5 hclk = ~hclk;
	assign hready = hreadyout;
	always @(posedge hclk) begin
		rdy_q <= hready;
		rd_q <= hrdata;
	end
	sdc_straps STRAPS (.hclk(hclk), .cfg(cfg), .mode(mode), .pin_pre_div_sel(p_pre), .pin_fb_div(p_fb),
		.pin_post_div_code_a(p_code), .pin_half_rate_sel_b(p_half), .serial_mode_sel(smode));
	sdc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pin_pre_div_sel(p_pre), .pin_fb_div(p_fb), .pin_post_div_code_a(p_code), .pin_half_rate_sel_b(p_half),
		.serial_mode_sel(smode), .pll_lock(pll_lock), .fb_div_q(fbq), .pre_div_sel_q(preq),
		.post_div_code_a_q(codeq), .half_rate_sel_b_q(halfq), .pre_div_ratio_q(ratio), .out_a_div_q(oa),
		.out_b_div_q(ob), .cfg_unsupported_q(unsup), .parallel_mode_q(pm), .init_done_q(idn));
	// =====================================
	// tasks
	task automatic finish_test;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_rdy;
		n = 0;
		do begin
			@(posedge hclk);
			#1;
			n++;
		end while (rdy_q !== 1'b1 && n < 20);
		if (rdy_q !== 1'b1) begin
			miscompares++;
			finish_test;
		end
	endtask : wait_rdy
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
		wait_rdy;
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		wait_rdy;
		r = rd_q;
	endtask : xfer
	task automatic set_pins(input logic [14:0] v);
		cfg <= v;
		repeat (5) @(posedge hclk);
		#1;
	endtask : set_pins
	function automatic logic [31:0] exp_cfg(input logic [14:0] v);
		logic u;
		logic [5:0] a;
		u = v[3:1] == 3'h7 || (v[0] && (v[3:1] == 3'h1 || v[3:1] == 3'h3));
		a = u ? 6'h00 : na_tbl[v[3:1]];
		return {v[13:4], v[14], v[3:1], v[0], v[14] ? 3'h4 : 3'h2, a, u ? 7'h00 : (v[0] ? {a, 1'b0} : {1'b0, a}), u};
	endfunction : exp_cfg
	// =====================================
	// main sequence
	initial begin
		{hsel, htrans, haddr, hwrite, hsize, hwdata, pll_lock, mode, hresetn} = '0;
		hsize = 3'h2;
		cfg = {1'b1, 10'h1f4, 3'h2, 1'b0};
		miscompares = 0;
		checks_done = 0;
		repeat (16) @(posedge hclk);
		chk(cfg_vec, exp_cfg(cfg));
		chk({30'h0, pm, idn}, 32'h0);
		hresetn <= 1'b1;
		set_pins(cfg);
		chk(cfg_vec, exp_cfg(cfg));
		chk({30'h0, pm, idn}, 32'h3);
		xfer(1'b0, `SDC_ADDR_PLL_L, 32'h0);
		chk(r, 32'hf4);
		xfer(1'b0, `SDC_ADDR_PLL_H, 32'h0);
		chk(r, 32'h52);
		for (int i = 0; i < 16; i++) begin
			c = {i[0], i[3:0], i[3:0], 2'h3, i[2:0], i[3]};
			set_pins(c);
			chk(cfg_vec, exp_cfg(c));
		end
		xfer(1'b1, `SDC_ADDR_PLL_L, 32'h11);
		xfer(1'b0, `SDC_ADDR_PLL_L, 32'h0);
		chk(r, 32'hf4);
		mode <= 1'b1;
		set_pins({1'b1, 10'h1f4, 3'h2, 1'b0});
		chk(cfg_vec, exp_cfg(c));
		chk({30'h0, pm, idn}, 32'h1);
		xfer(1'b1, `SDC_ADDR_PLL_L, 32'h23);
		xfer(1'b1, `SDC_ADDR_PLL_H, 32'h55);
		xfer(1'b0, `SDC_ADDR_PLL_H, 32'h0);
		chk(r, 32'h54);
		xfer(1'b1, `SDC_ADDR_CMD, 32'h4);
		@(posedge hclk);
		#1;
		chk(cfg_vec, exp_cfg({1'b0, 10'h123, 3'h2, 1'b1}));
		xfer(1'b1, `SDC_ADDR_CMD, 32'h1);
		xfer(1'b1, `SDC_ADDR_CMD, 32'h2);
		xfer(1'b1, `SDC_ADDR_CMD, 32'h2);
		@(posedge hclk);
		#1;
		chk({22'h0, fbq}, 32'h122);
		pll_lock <= 1'b1;
		xfer(1'b1, `SDC_ADDR_CMD, 32'h8);
		xfer(1'b0, `SDC_ADDR_PLL_L, 32'h0);
		chk(r, 32'h22);
		xfer(1'b0, `SDC_ADDR_PLL_H, 32'h0);
		chk(r, 32'h55);
		xfer(1'b0, 32'h10, 32'h0);
		chk(r, 32'h0);
		xfer(1'b0, `SDC_ADDR_CMD, 32'h0);
		chk(r, 32'h0);
		mode <= 1'b0;
		set_pins(cfg);
		chk(cfg_vec, exp_cfg(cfg));
		chk({30'h0, pm, idn}, 32'h3);
		hresetn <= 1'b0;
		mode <= 1'b1;
		c = {1'b0, 10'h155, 3'h5, 1'b1};
		set_pins(c);
		hresetn <= 1'b1;
		set_pins(c);
		chk(cfg_vec, exp_cfg(c));
		chk({30'h0, pm, idn}, 32'h1);
		xfer(1'b0, `SDC_ADDR_PLL_L, 32'h0);
		chk(r, 32'h55);
		finish_test;
	end
endmodule : tb_synth_divider_config
